//--- hdl/cioc_pkg.sv
// Package: constants and types for the configurable I/O converter control
`default_nettype none
package cioc_pkg;
   // -----------------------------------------------------------------
   // Serial command frame
   // -----------------------------------------------------------------
   typedef struct packed {
      logic is_dac;
      logic [3:0] addr;
      logic [10:0] body;
   } cioc_cmd_t;

   typedef struct packed {
      logic [3:0] tag;
      logic [11:0] code;
   } cioc_result_t;

   localparam logic [4:0] FRAME_BITS = 5'h10;

   // Control register address codes
   localparam logic [3:0] REG_NOP = 4'h0;
   localparam logic [3:0] REG_SEQ = 4'h2;
   localparam logic [3:0] REG_GPCTRL = 4'h3;
   localparam logic [3:0] REG_ADC_CFG = 4'h4;
   localparam logic [3:0] REG_DAC_CFG = 4'h5;
   localparam logic [3:0] REG_PULLDOWN = 4'h6;
   localparam logic [3:0] REG_DEFERRED_DAC_UPDATE = 4'h7;
   localparam logic [3:0] REG_GPIO_WCFG = 4'h8;
   localparam logic [3:0] REG_GPIO_DATA = 4'h9;
   localparam logic [3:0] REG_GPIO_RCFG = 4'ha;
   localparam logic [3:0] REG_PWR_REF = 4'hb;
   localparam logic [3:0] REG_OPEN_DRAIN = 4'hc;
   localparam logic [3:0] REG_SW_RESET = 4'hf;

   // Defaults and keys
   localparam logic [10:0] PULLDOWN_DEF = 11'h0ff;
   localparam logic [10:0] SW_RESET_KEY = 11'h5ac;

   // Field positions inside the 11-bit register body
   localparam int SEQ_TEMP_BIT = 8;
   localparam int RANGE_BIT = 5;
   localparam int ADC_BUF_BIT = 8;
   localparam int BUSY_PIN_BIT = 8;
   localparam int READBACK_BIT = 10;
   localparam int REF_EN_BIT = 9;
   localparam int DEFERRED_DAC_UPDATE_DEFER_BIT = 0;
   localparam int DEFERRED_DAC_UPDATE_LOAD_BIT = 1;
   localparam int BUSY_PIN = 7;
   localparam logic [3:0] TEMP_TAG = 4'h8;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_NS = 2000;
   localparam int TEMP_BUF_NS = 5000;
   localparam int TEMP_UNBUF_NS = 20000;
   localparam int RESET_NS = 250000;
   localparam logic [9:0] CONV_CYC = 10'(CONV_NS / CLK_PERIOD_NS);
   localparam logic [9:0] TEMP_BUF_CYC = 10'(TEMP_BUF_NS / CLK_PERIOD_NS);
   localparam logic [9:0] TEMP_UNBUF_CYC =
      10'(TEMP_UNBUF_NS / CLK_PERIOD_NS);
   localparam int RESET_CYC_DEF = RESET_NS / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // APB map
   // -----------------------------------------------------------------
   localparam logic [7:0] APB_STATUS = 8'h00;
   localparam logic [7:0] APB_ADC_SAMPLE = 8'h04;
   localparam logic [7:0] APB_LAST_CMD = 8'h08;
   localparam logic [2:0] APB_DAC_PAGE = 3'h1;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_TRACK = 2'b01,
      SEQ_CONV = 2'b10
   } cioc_seq_t;
endpackage
`default_nettype wire

//--- hdl/cioc_ctrl.sv
// Control logic of the eight-pin configurable converter device
//
// The register addresses and the APB slave port are this design's own decisions.
`default_nettype none
module cioc_ctrl
   import cioc_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_CYC_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic [7:0] channel_pins_in,
   output logic [7:0] channel_pins_out,
   output logic [7:0] channel_pins_oe_n,
   output logic [7:0] pulldown_en,
   output logic [7:0] dac_powerdown,
   output logic ref_en,
   output logic adc_range_x2
);
   // -----------------------------------------------------------------
   // Synchronisers and edge detection
   // -----------------------------------------------------------------
   logic sclk_s1, sclk_s2, sclk_s3;
   logic sync_s1, sync_s2, sync_s3;
   logic sin_s1, sin_s2;
   logic [7:0] pin_s1, pin_s2;
   logic sclk_fall, sync_fall, sync_rise;

   // Two flops before use; third flop only remembers the last level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sync_s1 <= 1'b1;
         sync_s2 <= 1'b1;
         sync_s3 <= 1'b1;
         sin_s1 <= 1'b0;
         sin_s2 <= 1'b0;
         pin_s1 <= 8'h00;
         pin_s2 <= 8'h00;
      end else begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sync_s1 <= sync_n;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
         sin_s1 <= serial_in;
         sin_s2 <= sin_s1;
         pin_s1 <= channel_pins_in;
         pin_s2 <= pin_s1;
      end
   end

   assign sclk_fall = sclk_s3 & ~sclk_s2;
   assign sync_fall = sync_s3 & ~sync_s2;
   assign sync_rise = ~sync_s3 & sync_s2;

   // -----------------------------------------------------------------
   // Serial frame capture and shift-out
   // -----------------------------------------------------------------
   logic [15:0] rx_r, tx_r, tx_load;
   logic [4:0] bit_cnt_r;
   logic serial_out_r;
   logic exec, soft_rst, rst_busy;
   cioc_cmd_t cmd;
   logic gpio_rb_r, res_valid_r;
   cioc_result_t res_r;

   assign cmd = cioc_cmd_t'(rx_r);
   // Frame executes only after a full sixteen bits, never mid-reset
   assign exec = sync_rise && bit_cnt_r == FRAME_BITS && !rst_busy;
   assign soft_rst = exec && !cmd.is_dac && cmd.addr == REG_SW_RESET
      && cmd.body == SW_RESET_KEY;

   // Readback takes priority over a pending conversion result
   always_comb begin
      tx_load = 16'h0000;
      if (gpio_rb_r) begin
         tx_load = {8'h00, pin_s2};
      end else if (res_valid_r) begin
         tx_load = res_r;
      end
   end

   // Capture on serial clock fall, shift out after the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r <= 16'h0000;
         tx_r <= 16'h0000;
         bit_cnt_r <= 5'h00;
         serial_out_r <= 1'b0;
      end else if (sync_fall) begin
         bit_cnt_r <= 5'h00;
         tx_r <= tx_load;
         serial_out_r <= tx_load[15];
      end else if (sclk_fall && !sync_s2) begin
         rx_r <= {rx_r[14:0], sin_s2};
         tx_r <= {tx_r[14:0], 1'b0};
         serial_out_r <= tx_r[14];
         if (bit_cnt_r != FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // Reset processing time
   // -----------------------------------------------------------------
   logic [15:0] rst_cnt_r;

   // Frames are ignored until the reset work has run out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_r <= 16'(RESET_CYCLES);
      end else if (soft_rst) begin
         rst_cnt_r <= 16'(RESET_CYCLES);
      end else if (rst_cnt_r != 16'h0000) begin
         rst_cnt_r <= rst_cnt_r - 16'h0001;
      end
   end
   assign rst_busy = rst_cnt_r != 16'h0000;

   // -----------------------------------------------------------------
   // Control register file
   // -----------------------------------------------------------------
   logic [10:0] ctl_r [0:15];
   logic [7:0] dac_cfg, gpio_wcfg, gpio_rcfg, gpio_data, od_cfg;
   logic [8:0] seq_sel;
   logic deferred_dac_update_defer;

   // One store for the whole map; fields are taken by name below
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 16; i++) begin
            ctl_r[i] <= (4'(i) == REG_PULLDOWN) ? PULLDOWN_DEF : 11'h000;
         end
      end else if (soft_rst) begin
         for (int i = 0; i < 16; i++) begin
            ctl_r[i] <= (4'(i) == REG_PULLDOWN) ? PULLDOWN_DEF : 11'h000;
         end
      end else if (exec && !cmd.is_dac && cmd.addr != REG_NOP) begin
         ctl_r[cmd.addr] <= cmd.body;
      end
   end

   assign dac_cfg = ctl_r[REG_DAC_CFG][7:0];
   assign gpio_wcfg = ctl_r[REG_GPIO_WCFG][7:0];
   assign gpio_rcfg = ctl_r[REG_GPIO_RCFG][7:0];
   assign gpio_data = ctl_r[REG_GPIO_DATA][7:0];
   assign od_cfg = ctl_r[REG_OPEN_DRAIN][7:0];
   assign seq_sel = ctl_r[REG_SEQ][8:0];
   assign deferred_dac_update_defer = ctl_r[REG_DEFERRED_DAC_UPDATE][DEFERRED_DAC_UPDATE_DEFER_BIT];

   // -----------------------------------------------------------------
   // DAC input and output registers
   // -----------------------------------------------------------------
   logic [11:0] dac_in_r [0:7];
   logic [11:0] dac_out_r [0:7];
   logic dac_wr, deferred_dac_update_load;
   logic [2:0] dac_ch;

   // Channel sits in the three bits just below the top bit
   assign dac_ch = rx_r[14:12];
   assign dac_wr = exec && cmd.is_dac && dac_cfg[dac_ch];
   assign deferred_dac_update_load = exec && !cmd.is_dac && cmd.addr == REG_DEFERRED_DAC_UPDATE
      && cmd.body[DEFERRED_DAC_UPDATE_LOAD_BIT];

   // Deferred mode parks data in the input stage until a load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) begin
            dac_in_r[i] <= 12'h000;
            dac_out_r[i] <= 12'h000;
         end
      end else if (soft_rst) begin
         for (int i = 0; i < 8; i++) begin
            dac_in_r[i] <= 12'h000;
            dac_out_r[i] <= 12'h000;
         end
      end else if (dac_wr) begin
         dac_in_r[dac_ch] <= rx_r[11:0];
         if (!deferred_dac_update_defer) begin
            dac_out_r[dac_ch] <= rx_r[11:0];
         end
      end else if (deferred_dac_update_load) begin
         for (int i = 0; i < 8; i++) begin
            dac_out_r[i] <= dac_in_r[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // ADC sequencer
   // -----------------------------------------------------------------
   cioc_seq_t seq_st_r;
   logic [3:0] ptr_r, conv_ch_r;
   logic [9:0] conv_cnt_r;
   logic [11:0] adc_sample_r;
   logic busy_r;
   logic seq_wr;

   // Next selected entry after cur, wrapping; entry 8 is temperature
   function automatic logic [3:0] next_sel(input logic [8:0] sel,
                                           input logic [3:0] cur);
      logic [3:0] found;
      logic [3:0] idx;
      found = cur;
      for (int k = 9; k >= 1; k--) begin
         idx = 4'((32'(cur) + k) % 9);
         if (sel[idx]) begin
            found = idx;
         end
      end
      return found;
   endfunction

   assign seq_wr = exec && !cmd.is_dac && cmd.addr == REG_SEQ;

   // Sync fall starts a conversion; host spacing keeps them apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_st_r <= SEQ_IDLE;
         ptr_r <= 4'h0;
         conv_ch_r <= 4'h0;
         conv_cnt_r <= 10'h000;
         busy_r <= 1'b1;
         res_valid_r <= 1'b0;
         res_r <= '0;
      end else if (soft_rst) begin
         seq_st_r <= SEQ_IDLE;
         ptr_r <= 4'h0;
         conv_ch_r <= 4'h0;
         conv_cnt_r <= 10'h000;
         busy_r <= 1'b1;
         res_valid_r <= 1'b0;
      end else begin
         if (sync_fall) begin
            res_valid_r <= 1'b0;
         end
         if (seq_wr) begin
            ptr_r <= next_sel(cmd.body[8:0], 4'h8);
            seq_st_r <= (cmd.body[8:0] != 9'h000) ? SEQ_TRACK : SEQ_IDLE;
         end else if (sync_fall && seq_st_r != SEQ_IDLE
                      && seq_sel != 9'h000) begin
            // Selection is not gated by the pin role: DAC pins convert too
            conv_ch_r <= ptr_r;
            ptr_r <= next_sel(seq_sel, ptr_r);
            seq_st_r <= SEQ_CONV;
            busy_r <= 1'b0;
            if (ptr_r == TEMP_TAG) begin
               conv_cnt_r <= ctl_r[REG_GPCTRL][ADC_BUF_BIT] ?
                  TEMP_BUF_CYC : TEMP_UNBUF_CYC;
            end else begin
               conv_cnt_r <= CONV_CYC;
            end
         end else if (seq_st_r == SEQ_CONV) begin
            if (conv_cnt_r == 10'h001) begin
               seq_st_r <= SEQ_TRACK;
               busy_r <= 1'b1;
               res_valid_r <= 1'b1; // set after clear, so it wins
               res_r.tag <= conv_ch_r;
               res_r.code <= adc_sample_r;
            end
            conv_cnt_r <= conv_cnt_r - 10'h001;
         end
      end
   end

   // -----------------------------------------------------------------
   // GPIO readback request
   // -----------------------------------------------------------------
   // Armed by the read-configuration write, spent by the next frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_rb_r <= 1'b0;
      end else if (soft_rst) begin
         gpio_rb_r <= 1'b0;
      end else if (exec && !cmd.is_dac && cmd.addr == REG_GPIO_RCFG) begin
         gpio_rb_r <= cmd.body[READBACK_BIT];
      end else if (sync_fall) begin
         gpio_rb_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Pin drive, one slice per channel pin
   // -----------------------------------------------------------------
   logic [7:0] pin_out_r, pin_oe_n_r;
   logic busy_pin_mode;

   assign busy_pin_mode = ctl_r[REG_GPIO_WCFG][BUSY_PIN_BIT];

   for (genvar g = 0; g < 8; g++) begin : g_pin
      logic drive, level;
      always_comb begin
         drive = gpio_wcfg[g] & ~dac_cfg[g];
         level = gpio_data[g];
         if (g == BUSY_PIN && busy_pin_mode) begin
            drive = 1'b1;
            level = busy_r;
         end
      end
      // Open drain only pulls low; it floats for a one
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_out_r[g] <= 1'b0;
            pin_oe_n_r[g] <= 1'b1;
         end else begin
            pin_out_r[g] <= level;
            pin_oe_n_r[g] <= ~(drive & (~od_cfg[g] | ~level));
         end
      end
   end

   // -----------------------------------------------------------------
   // Analog-side control outputs
   // -----------------------------------------------------------------
   logic [7:0] pulldown_r, dac_pd_r;
   logic ref_en_r, range_r;

   // Registered copies so every output leaves a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulldown_r <= 8'hff;
         dac_pd_r <= 8'h00;
         ref_en_r <= 1'b0;
         range_r <= 1'b0;
      end else begin
         pulldown_r <= ctl_r[REG_PULLDOWN][7:0] & ~(dac_cfg | gpio_wcfg);
         dac_pd_r <= ctl_r[REG_PWR_REF][7:0];
         ref_en_r <= ctl_r[REG_PWR_REF][REF_EN_BIT];
         range_r <= ctl_r[REG_GPCTRL][RANGE_BIT];
      end
   end

   // -----------------------------------------------------------------
   // APB slave: one wait state, error on unmapped addresses
   // -----------------------------------------------------------------
   logic [31:0] prdata_r, rd_mux;
   logic pready_r, pslverr_r, mapped;
   logic [15:0] last_cmd_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      if (paddr[7:5] == APB_DAC_PAGE && paddr[1:0] == 2'b00) begin
         rd_mux = {20'h0_0000, dac_out_r[paddr[4:2]]};
      end else if (paddr == APB_STATUS) begin
         rd_mux = {23'h00_0000, rst_busy, res_valid_r, ~busy_r,
                   seq_st_r, conv_ch_r};
      end else if (paddr == APB_ADC_SAMPLE) begin
         rd_mux = {20'h0_0000, adc_sample_r};
      end else if (paddr == APB_LAST_CMD) begin
         rd_mux = {16'h0000, last_cmd_r};
      end else begin
         mapped = 1'b0;
      end
   end

   // Answer on the second access cycle; write lands with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         adc_sample_r <= 12'h000;
      end else if (psel && penable && !pready_r) begin
         pready_r <= 1'b1;
         pslverr_r <= ~mapped;
         prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         // Write commits on the edge where the master sees pready
         if (psel && penable && pwrite && paddr == APB_ADC_SAMPLE) begin
            adc_sample_r <= pwdata[11:0];
         end
      end
   end

   // Last executed frame, for software inspection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cmd_r <= 16'h0000;
      end else if (exec) begin
         last_cmd_r <= rx_r;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign serial_out = serial_out_r;
   assign channel_pins_out = pin_out_r;
   assign channel_pins_oe_n = pin_oe_n_r;
   assign pulldown_en = pulldown_r;
   assign dac_powerdown = dac_pd_r;
   assign ref_en = ref_en_r;
   assign adc_range_x2 = range_r;
endmodule
`default_nettype wire

//--- bench/cioc_ctrl_monitor.sv
// Concurrent checks on the converter control block ports
`default_nettype none
module cioc_ctrl_monitor #(
   parameter int RESET_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_n,
   input wire logic [7:0] channel_pins_out,
   input wire logic [7:0] channel_pins_oe_n,
   input wire logic [7:0] pulldown_en,
   input wire logic [7:0] dac_powerdown,
   input wire logic ref_en,
   input wire logic adc_range_x2
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----
   // Helper counters
   // -----
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] hi_cnt_r;
   logic [15:0] rel_cnt_r;

   // Cycles since frame sync went high, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt_r <= 4'h0;
      end else if (!sync_n) begin
         hi_cnt_r <= 4'h0;
      end else if (hi_cnt_r != 4'hf) begin
         hi_cnt_r <= hi_cnt_r + 4'h1;
      end
   end

   // Cycles since reset release, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_cnt_r <= 16'h0000;
      end else if (rel_cnt_r != 16'hffff) begin
         rel_cnt_r <= rel_cnt_r + 16'h0001;
      end
   end

   // -----
   // Properties
   // -----
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_busy_low;
      !channel_pins_out[7] [*8];
   endsequence

   a_ready_answer: assert property (s_access |=> pready)
      else $error("pready missing after access edge");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_reset_values: assert property ($rose(presetn) |->
      !ref_en && pulldown_en == 8'hff && channel_pins_oe_n == 8'hff)
      else $error("outputs not at defaults after reset");
   a_exec_at_rise: assert property (
      $changed({dac_powerdown, adc_range_x2}) |-> hi_cnt_r inside {[1:10]})
      else $error("control changed away from frame end");
   a_ref_at_rise: assert property ($rose(ref_en) |->
      sync_n && $past(sync_n))
      else $error("reference enabled inside a frame");
   a_reset_hold: assert property (
      $changed({ref_en, dac_powerdown, pulldown_en}) |->
      rel_cnt_r >= RESET_CYCLES)
      else $error("control changed in reset window");
   a_busy_low: assert property ($fell(channel_pins_out[7]) &&
      !channel_pins_oe_n[7] && !sync_n |=> s_busy_low)
      else $error("busy pin not held low in conversion");
endmodule

bind cioc_ctrl cioc_ctrl_monitor #(.RESET_CYCLES(RESET_CYCLES)) mon_u (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .sync_n,
   .channel_pins_out, .channel_pins_oe_n, .pulldown_en, .dac_powerdown,
   .ref_en, .adc_range_x2
);
`default_nettype wire

//--- bench/cioc_host.sv
// Host serial port model that sends 16-bit frames
`default_nettype none
module cioc_host (
   output logic sclk,
   output logic sync_n,
   output logic serial_in,
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF_NS = 100;
   // Gap covers tracking and the longest conversion
   localparam int GAP_NS = 21000;

   // Idle: clock stands low, sync high
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      serial_in = 1'b0;
   end

   // Data changes on rise so the device's fall sample sees it stable
   task automatic send(input logic [15:0] w, output logic [15:0] rx);
      // Non-blocking so a change on a pclk edge is seen after it
      sync_n <= 1'b0;
      #(HALF_NS);
      for (int i = 15; i >= 0; i--) begin
         sclk <= 1'b1;
         serial_in <= w[i];
         #(HALF_NS);
         rx[i] = serial_out;
         sclk <= 1'b0;
         #(HALF_NS);
      end
      sync_n <= 1'b1;
      serial_in <= ~serial_in; // Flip the line after the frame; the device ignores it while sync is high
      #(GAP_NS);
   endtask
endmodule
`default_nettype wire

//--- bench/tb_cioc_ctrl.sv
// Self-checking testbench for the converter control block
`default_nettype none
module tb_cioc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_CYC = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic sclk, sync_n, serial_in, serial_out, ref_en, adc_range_x2;
   logic [7:0] paddr, channel_pins_in, channel_pins_out;
   logic [7:0] channel_pins_oe_n, pulldown_en, dac_powerdown;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] rx;
   logic [15:0] seq_exp [5] = '{16'h0000, 16'h0123, 16'h1123, 16'h8123,
      16'h0123};
   int err_total, tests_run;

   cioc_ctrl #(.RESET_CYCLES(RST_CYC)) dut_u (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sclk, .sync_n, .serial_in, .serial_out, .channel_pins_in,
      .channel_pins_out, .channel_pins_oe_n, .pulldown_en, .dac_powerdown,
      .ref_en, .adc_range_x2);
   cioc_host host_u (.sclk, .sync_n, .serial_in, .serial_out);

   // Pin level: device drive where enabled, else a fixed pattern
   assign channel_pins_in = (~channel_pins_oe_n & channel_pins_out) |
      (channel_pins_oe_n & 8'ha1);

   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // -----
   // Tasks
   // -----
   task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask

   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] a,
      input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, x, q);
   endtask

   task automatic fr(input logic [15:0] w);
      host_u.send(w, rx);
   endtask

   task automatic hw_reset();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog: the frames need about half a millisecond
   initial begin
      #1_000_000;
      err_total++;
      wrap_up();
   end

   // -----
   // Tests
   // -----
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      err_total = 0;
      tests_run = 0;
      hw_reset();
      chk("oe_n", 8'hff, channel_pins_oe_n);
      chk("ref_en", 1'b0, ref_en);
      rd("status", 8'h00, 32'h0000_0100);
      repeat (RST_CYC) @(posedge pclk);
      rd("status", 8'h00, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("slverr", 1'b1, e);
      $display("test reset done");
      fr(16'h5a05);
      chk("ref_en", 1'b1, ref_en);
      chk("dac_pd", 8'h05, dac_powerdown);
      fr(16'h1820);
      chk("range", 1'b1, adc_range_x2);
      rd("last_cmd", 8'h08, 32'h0000_1820);
      $display("test control done");
      fr(16'h2801);
      fr(16'h8abc);
      rd("dac0", 8'h20, 32'h0000_0abc);
      fr(16'h9123);
      rd("dac1", 8'h24, 32'h0000_0000);
      fr(16'h3801);
      fr(16'h8555);
      rd("dac0", 8'h20, 32'h0000_0abc);
      fr(16'h3802);
      rd("dac0", 8'h20, 32'h0000_0555);
      $display("test dac done");
      fr(16'h410c);
      fr(16'h4804);
      chk("pins_out", 8'h04, channel_pins_out & 8'h0c);
      chk("oe_n", 8'h00, channel_pins_oe_n & 8'h0c);
      fr(16'h5408);
      fr(16'h0000);
      chk("readback", 16'h00a5, rx);
      $display("test gpio done");
      apb(1'b1, 8'h04, 32'h0000_0123);
      rd("sample", 8'h04, 32'h0000_0123);
      fr(16'h1103);
      foreach (seq_exp[i]) begin
         fr(16'h0000);
         chk("result", seq_exp[i], rx);
      end
      chk("busy", 1'b1, channel_pins_out[7]);
      $display("test sequence done");
      fr(16'h7dac);
      chk("ref_en", 1'b0, ref_en);
      chk("range", 1'b0, adc_range_x2);
      chk("pulldown", 8'hff, pulldown_en);
      repeat (RST_CYC) @(posedge pclk);
      fr(16'h5a00);
      chk("ref_en", 1'b1, ref_en);
      hw_reset();
      chk("ref_en", 1'b0, ref_en);
      chk("pulldown", 8'hff, pulldown_en);
      $display("test resets done");
      wrap_up();
   end
endmodule
`default_nettype wire
